// >>> src/hpdp_cfg.svh
// Constants of the host parallel data port
`ifndef HPDP_CFG_SVH
`define HPDP_CFG_SVH
`define HPDP_DW         16
`define HPDP_BW         8
`define HPDP_HI_MSB     15
`define HPDP_HI_LSB     8
`define HPDP_LO_MSB     7
`define HPDP_LO_LSB     0
`define HPDP_SEL_STATUS 1'h1
`define HPDP_SEL_DATA   1'h0
`define HPDP_SEL_HIGH   1'h1
`define HPDP_WORD_RST   16'h0000
// Idle control pins: chip-select and strobes high, selects low
`define HPDP_CTL_IDLE   5'h1C
// Data bus enables: released, low lane only, whole word
`define HPDP_OE_NONE    16'h0000
`define HPDP_OE_BYTE    16'h00FF
`define HPDP_OE_WORD    16'hFFFF
// Status bits: 0 outbound word waiting for host, 1 inbound word waiting for core
`define HPDP_ST_OUT_FULL 0
`define HPDP_ST_IN_FULL  1
`endif

// >>> src/hpdp_pkg.sv
// Types of the host parallel data port
package hpdp_pkg;
  typedef struct packed
  {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       reg_sel;
    logic       byte_sel;
  } hpdp_ctl_t;

  typedef struct packed
  {
    logic [15:0] data;
    logic [15:0] oe;
  } hpdp_drv_t;
endpackage

// >>> src/hpdp_port.sv
// Host parallel data port: host-side pins, core-side word handshakes
//
// Contract
// - Register-select high: reads and writes reach the status register.
// - Select low with read strobe: drive the outbound data register.
// - Select low with write strobe: capture bus into inbound data register.
// - Byte mode: byte-select high takes bits 15..8, low takes 7..0.
// - Byte-select counts only in 8-bit mode; 16-bit mode moves whole words.
// - Data bus released unless a host read is under way.
`timescale 1ns/1ps
`include "hpdp_cfg.svh"
module hpdp_port
  import hpdp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_byte_mode,
  input  wire logic        i_host_chip_select_n,
  input  wire logic        i_host_read_strobe_n,
  input  wire logic        i_host_write_strobe_n,
  input  wire logic        i_host_reg_select,
  input  wire logic        i_host_byte_select,
  input  wire logic [15:0] i_host_data_bus,
  output logic      [15:0] o_host_data_bus,
  output logic      [15:0] o_host_data_oe,
  output logic             o_host_read_enable_out,
  output logic             o_host_write_enable_out,
  input  wire logic        i_core_out_valid,
  input  wire logic [15:0] i_core_out_data,
  output logic             o_core_out_ready,
  output logic             o_core_in_valid,
  output logic      [15:0] o_core_in_data,
  input  wire logic        i_core_in_ready,
  output logic      [15:0] o_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  hpdp_ctl_t   meta_ff;
  hpdp_ctl_t   ctl_ff;
  hpdp_ctl_t   ctl_d_ff;
  logic [15:0] dmeta_ff;
  logic [15:0] din_ff;

  // Two stages on every host pin; the first stage never feeds logic.
  // The data word is not coded: the host holds it steady around the strobe,
  // so a skewed first-stage sample has settled before the trailing edge uses it.
  // The third control stage holds the previous level for edge finding and the selects of the access just ended.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Idle pin levels, so no false strobe edge follows reset
      meta_ff  <= `HPDP_CTL_IDLE;
      ctl_ff   <= `HPDP_CTL_IDLE;
      ctl_d_ff <= `HPDP_CTL_IDLE;
      dmeta_ff <= `HPDP_WORD_RST;
      din_ff   <= `HPDP_WORD_RST;
    end
    else
    begin
      meta_ff  <= '{i_host_chip_select_n, i_host_read_strobe_n, i_host_write_strobe_n,
                    i_host_reg_select, i_host_byte_select};
      ctl_ff   <= meta_ff;
      ctl_d_ff <= ctl_ff;
      dmeta_ff <= i_host_data_bus;
      din_ff   <= dmeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification
  logic rd_act;
  logic wr_act;
  logic wr_end;
  logic rd_end;
  logic hi_byte;

  // Strobes count only under chip-select
  assign rd_act  = !ctl_ff.cs_n && !ctl_ff.rd_n;
  assign wr_act  = !ctl_ff.cs_n && !ctl_ff.wr_n;
  // Write data is taken at the trailing edge, when the host bus has settled
  assign wr_end  = !ctl_d_ff.cs_n && !ctl_d_ff.wr_n && ctl_ff.wr_n;
  assign rd_end  = !ctl_d_ff.cs_n && !ctl_d_ff.rd_n && ctl_ff.rd_n;
  // Byte-select is ignored in word mode
  assign hi_byte = i_byte_mode && (ctl_d_ff.byte_sel == `HPDP_SEL_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Data registers and full flags
  logic [15:0] out_reg_ff;
  logic [15:0] in_reg_ff;
  logic        out_full_ff;
  logic        in_full_ff;
  logic        out_done;
  logic        in_done;

  // Word transfer completes on whole word, or on the high byte in byte mode.
  // Writes with register-select high reach the read-only status word and are
  // dropped, since both completions demand the data select
  assign out_done = rd_end && (ctl_d_ff.reg_sel == `HPDP_SEL_DATA)
                    && (!i_byte_mode || hi_byte);
  assign in_done  = wr_end && (ctl_d_ff.reg_sel == `HPDP_SEL_DATA)
                    && (!i_byte_mode || hi_byte);

  // Outbound register loads from the core while empty
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      out_reg_ff <= `HPDP_WORD_RST;
    else if (i_core_out_valid && !out_full_ff)
      out_reg_ff <= i_core_out_data;
  end

  // Host read of the last byte empties it; a core load in that cycle is refused
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      out_full_ff <= 1'b0;
    else if (!out_full_ff && i_core_out_valid)
      out_full_ff <= 1'b1;
    else if (out_done)
      out_full_ff <= 1'b0;
  end

  // Inbound capture by byte lane
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      in_reg_ff <= `HPDP_WORD_RST;
    else if (wr_end && ctl_d_ff.reg_sel == `HPDP_SEL_DATA)
    begin
      if (!i_byte_mode)
        in_reg_ff <= din_ff;
      else if (hi_byte)
        in_reg_ff[`HPDP_HI_MSB:`HPDP_HI_LSB] <= din_ff[`HPDP_LO_MSB:`HPDP_LO_LSB];
      else
        in_reg_ff[`HPDP_LO_MSB:`HPDP_LO_LSB] <= din_ff[`HPDP_LO_MSB:`HPDP_LO_LSB];
    end
  end

  // Host write sets full; set wins over a core take in the same cycle.
  // Limitation: a host write while still full overwrites the held word, so
  // the host must watch the write enable before each write.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      in_full_ff <= 1'b0;
    else if (in_done)
      in_full_ff <= 1'b1;
    else if (i_core_in_ready)
      in_full_ff <= 1'b0;
  end

  // Core handshakes: valid is held back in the cycle a new word lands
  assign o_core_out_ready = !out_full_ff;
  assign o_core_in_valid  = in_full_ff && !in_done;
  assign o_core_in_data   = in_reg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Status and host read path
  logic [15:0] status;
  logic [15:0] rd_word;
  logic [15:0] rd_data_ff;
  logic        rd_oe_ff;

  // Status word: two flag bits, every other bit reads as zero
  always_comb
  begin
    status = 16'h0000;
    status[`HPDP_ST_OUT_FULL] = out_full_ff;
    status[`HPDP_ST_IN_FULL]  = in_full_ff;
  end
  assign o_status = status;

  // Register choice
  assign rd_word = (ctl_ff.reg_sel == `HPDP_SEL_STATUS) ? status : out_reg_ff;

  // Read data held in flops; byte mode moves the chosen half to the low lane.
  // It reaches the pins three clocks after the strobe falls at the pin.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rd_data_ff <= `HPDP_WORD_RST;
    else if (rd_act)
    begin
      if (!i_byte_mode)
        rd_data_ff <= rd_word;
      else if (ctl_ff.byte_sel == `HPDP_SEL_HIGH)
        rd_data_ff <= {8'h00, rd_word[`HPDP_HI_MSB:`HPDP_HI_LSB]};
      else
        rd_data_ff <= {8'h00, rd_word[`HPDP_LO_MSB:`HPDP_LO_LSB]};
    end
  end

  // Drive only during a qualified read; release at once otherwise
  // A write strobe at the same time means the host is driving, so hold off
  // rather than fight it on the bus
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rd_oe_ff <= 1'b0;
    else
      rd_oe_ff <= rd_act && !wr_act;
  end

  // Pin data straight from the read flops
  assign o_host_data_bus = rd_data_ff;

  // Enable drops with the synced strobe, not a clock later
  always_comb
  begin
    if (!(rd_oe_ff && rd_act))
      o_host_data_oe = `HPDP_OE_NONE;
    else if (i_byte_mode)
      o_host_data_oe = `HPDP_OE_BYTE; // Upper lane stays released
    else
      o_host_data_oe = `HPDP_OE_WORD;
  end

  // Enables tell the host a word can be read or written; both come from flag
  // flops, so the host never sees a glitch on them
  assign o_host_read_enable_out  = out_full_ff;
  assign o_host_write_enable_out = !in_full_ff;

endmodule

// >>> tb/hpdp_host_model.sv
// Host processor model
`timescale 1ns/1ps
module hpdp_host_model
  import hpdp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_dout,
  input  wire logic [15:0] i_oe,
  output hpdp_ctl_t        o_ctl,
  output logic      [15:0] o_bus
);
  logic [15:0] drv = 16'hFFFF;
  initial o_ctl = 5'h1C;
  // Wire level: device where enabled, else host or pull-up
  assign o_bus = (i_dout & i_oe) | (drv & ~i_oe);
  // Chip-select brackets the strobe; data held past it
  task automatic acc(input logic c, w, rs, bs, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge i_clk);
    o_ctl <= {c, 2'b11, rs, bs};
    drv <= w ? d : 16'hFFFF;
    @(posedge i_clk);
    o_ctl.rd_n <= w;
    o_ctl.wr_n <= !w;
    repeat (5) @(posedge i_clk);
    q = o_bus;
    o_ctl.rd_n <= 1'b1;
    o_ctl.wr_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_ctl.cs_n <= 1'b1;
    drv <= 16'hFFFF;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// >>> tb/hpdp_port_sva.sv
// Checker of the host port
`timescale 1ns/1ps
module hpdp_port_sva
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_byte_mode,
  input wire logic        i_host_chip_select_n,
  input wire logic        i_host_read_strobe_n,
  input wire logic        i_host_reg_select,
  input wire logic [15:0] o_host_data_bus,
  input wire logic [15:0] o_host_data_oe,
  input wire logic        o_core_in_valid,
  input wire logic [15:0] o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Read held long enough to clear the synchronisers
  sequence rd_held;
    (!i_host_chip_select_n && !i_host_read_strobe_n)[*5];
  endsequence
  a_read_word: assert property (rd_held ##0 !i_byte_mode
    |-> o_host_data_oe == 16'hFFFF) else $error("word read");
  a_read_byte: assert property (rd_held ##0 i_byte_mode
    |-> o_host_data_oe == 16'h00FF) else $error("byte read");
  a_status_read: assert property (rd_held ##0 i_host_reg_select && !i_byte_mode
    |-> o_host_data_bus == $past(o_status)) else $error("status read");
  a_bus_idle: assert property (i_host_read_strobe_n[*5]
    |-> o_host_data_oe == 16'h0000) else $error("bus idle");
  a_cs_gate: assert property (i_host_chip_select_n[*5]
    |-> o_host_data_oe == 16'h0000) else $error("cs gate");
  a_in_cause: assert property ($rose(o_status[1])
    |-> !$past(i_host_chip_select_n, 3)) else $error("in cause");
  a_in_valid: assert property ($rose(o_status[1])
    |=> o_core_in_valid) else $error("in valid");
endmodule
bind hpdp_port hpdp_port_sva hpdp_port_sva_inst (.i_clk, .i_rst, .i_byte_mode,
  .i_host_chip_select_n, .i_host_read_strobe_n, .i_host_reg_select, .o_host_data_bus,
  .o_host_data_oe, .o_core_in_valid, .o_status);

// >>> tb/hpdp_port_tb.sv
// Testbench of the host port
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h", $time, a); end end
module hpdp_port_tb;
  import hpdp_pkg::*;
  logic        clk = 0, rst = 1, bm = 0, ov = 0, ir = 0, civ, ren, wen, ordy;
  logic [15:0] od = 0, dout, oe, bus, q, cid, st;
  hpdp_ctl_t   ctl;
  int          miscompares = 0, tests_run = 0;
  always #25 clk = ~clk;
  hpdp_host_model hpdp_host_model_inst (.i_clk(clk), .i_dout(dout), .i_oe(oe),
    .o_ctl(ctl), .o_bus(bus));
  hpdp_port hpdp_port_inst (.i_clk(clk), .i_rst(rst), .i_byte_mode(bm),
    .i_host_chip_select_n(ctl.cs_n), .i_host_read_strobe_n(ctl.rd_n),
    .i_host_write_strobe_n(ctl.wr_n), .i_host_reg_select(ctl.reg_sel),
    .i_host_byte_select(ctl.byte_sel), .i_host_data_bus(bus), .o_host_data_bus(dout),
    .o_host_data_oe(oe), .o_host_read_enable_out(ren), .o_host_write_enable_out(wen),
    .i_core_out_valid(ov), .i_core_out_data(od), .o_core_out_ready(ordy),
    .o_core_in_valid(civ), .o_core_in_data(cid), .i_core_in_ready(ir), .o_status(st));
  task automatic h(input logic c, w, rs, bs, input logic [15:0] d);
    hpdp_host_model_inst.acc(c, w, rs, bs, d, q);
  endtask
  // Core side: one outbound word, one inbound word taken
  task automatic push(input logic [15:0] d);
    @(posedge clk) begin ov <= 1'b1; od <= d; end
    @(posedge clk) ov <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pop(input logic [15:0] d);
    `CHK(civ, 1'b1)
    `CHK(cid, d)
    @(posedge clk) ir <= 1'b1;
    @(posedge clk) ir <= 1'b0;
    @(posedge clk);
    `CHK(civ, 1'b0)
    `CHK(wen, 1'b1)
  endtask
  task automatic t_word;
    push(16'hA5C3);
    `CHK(ren, 1'b1)
    `CHK(ordy, 1'b0)
    h(0, 0, 1, 0, 0);
    `CHK(q, 16'h0001)
    h(0, 0, 0, 1, 0);
    `CHK(q, 16'hA5C3)
    `CHK(ren, 1'b0)
    h(0, 1, 0, 1, 16'h3C5A);
    `CHK(wen, 1'b0)
    h(0, 0, 1, 0, 0);
    `CHK(q, 16'h0002)
    pop(16'h3C5A);
  endtask
  // Strobes with chip-select high, and a status write, must change nothing
  task automatic t_cs;
    h(1, 1, 0, 0, 16'h1111);
    `CHK(st, 16'h0000)
    h(1, 0, 1, 0, 0);
    `CHK(q, 16'hFFFF)
    h(0, 1, 1, 0, 16'h7777);
    `CHK(st, 16'h0000)
    `CHK(cid, 16'h3C5A)
  endtask
  // Mid-run reset clears both flags and releases the bus
  task automatic t_reset;
    push(16'h0F0F);
    h(0, 1, 0, 0, 16'hF0F0);
    `CHK(st, 16'h0003)
    @(posedge clk) rst <= 1'b1;
    @(posedge clk);
    `CHK(st, 16'h0000)
    `CHK(ren, 1'b0)
    `CHK(wen, 1'b1)
    `CHK(ordy, 1'b1)
    `CHK(civ, 1'b0)
    `CHK(cid, 16'h0000)
    `CHK(oe, 16'h0000)
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_byte;
    @(posedge clk) bm <= 1'b1;
    push(16'h1234);
    h(0, 0, 0, 0, 0);
    `CHK(q, 16'hFF34)
    h(0, 0, 0, 1, 0);
    `CHK(q, 16'hFF12)
    h(0, 1, 0, 0, 16'h0078);
    h(0, 1, 0, 1, 16'h0056);
    pop(16'h5678);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_word;
    t_cs;
    t_reset;
    t_byte;
    give_verdict;
  end
  // Watchdog, several times the expected run
  initial
  begin
    #100000;
    miscompares++;
    give_verdict;
  end
endmodule
